// ==== pcsb_params.svh ====
`ifndef PCSB_PARAMS_SVH
`define PCSB_PARAMS_SVH

// ==========================================================
// function counts and live-bit masks
`define PCSB_PF_NUM        4
`define PCSB_VF_NUM        8
`define PCSB_FN_NUM        12
`define PCSB_PF_LIVE_MASK  4'h3
`define PCSB_VF_LIVE_MASK  8'h3f

// ==========================================================
// local fault vector layout
`define PCSB_LERR_NUM          12
`define PCSB_LERR_DEPTH        8
`define PCSB_LERR_REPLAY_RAM   0
`define PCSB_LERR_REQ_RAM      1
`define PCSB_LERR_CPL_RAM      2
`define PCSB_LERR_RX_OVF       3
`define PCSB_LERR_CPL_OVF      4
`define PCSB_LERR_REPLAY_TO    5
`define PCSB_LERR_REPLAY_ROLL  6
`define PCSB_LERR_PHY          7
`define PCSB_LERR_MALFORMED    8
`define PCSB_LERR_UNEXP_CPL    9
`define PCSB_LERR_FC_PROTO     10
`define PCSB_LERR_CPL_TIMEOUT  11

// ==========================================================
// reset values
`define PCSB_STS_RST  12'h000

`endif

// ==== pcsb_pkg.sv ====
// ==========================================================
// shared types
package pcsb_pkg;
	`include "pcsb_params.svh"

	// power-management state of the link side
	typedef enum logic {
		PCSB_PM_L0,
		PCSB_PM_L23_READY
	} pcsb_pm_e;

	// error message requests toward the link
	typedef struct packed {
		logic cor;
		logic uncor;
	} pcsb_errmsg_s;

	// link control toward the ltssm
	typedef struct packed {
		logic hold_quiet;
		logic link_to_l3;
	} pcsb_link_s;
endpackage : pcsb_pkg

// ==== pcsb_fault_q.sv ====
`timescale 1ns/1ps
`include "pcsb_params.svh"

// ==========================================================
// local fault event queue, drained one entry per cycle
module pcsb_fault_q #(
	parameter int WIDTH = `PCSB_LERR_NUM,
	parameter int DEPTH = `PCSB_LERR_DEPTH
) (
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	// event side
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] data_i,
	// report side
	output logic                  valid_o,
	output logic [WIDTH-1:0]      data_o,
	output logic                  drop_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, rd_q;
	logic [CW-1:0]    cnt_q;

	// ==========================================================
	// decode
	wire logic full  = (cnt_q == CW'(DEPTH));
	wire logic pop   = (cnt_q != '0);
	wire logic wr_en = push_i && (!full || pop);

	assign valid_o = pop;
	assign data_o  = mem_q[rd_q];
	assign drop_o  = push_i && full && !pop;

	// pointer wrap, shared by both pointers
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	// ==========================================================
	// storage; no reset on the array keeps it in plain ram
	always_ff @(posedge mclk_i) begin
		if (ce_i && wr_en) begin
			mem_q[wr_q] <= data_i;
		end
	end

	// pointers and fill count
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (ce_i) begin
			if (wr_en) wr_q <= ptr_inc(wr_q);
			if (pop) rd_q <= ptr_inc(rd_q);
			cnt_q <= cnt_q + CW'(wr_en) - CW'(pop);
		end
	end

	// ==========================================================
	// checks
	AST_FQ_BOUND: assert property (@(posedge mclk_i) disable iff (rst_i)
		cnt_q <= CW'(DEPTH))
		else $error("fault queue count above depth");

	AST_FQ_BURST: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && push_i && cnt_q == '0) |=> (cnt_q != '0 || !ce_i))
		else $error("fault event lost on empty queue");
endmodule : pcsb_fault_q

// ==== pcsb_top.sv ====
`timescale 1ns/1ps
`include "pcsb_params.svh"

// ==========================================================
// Overview of operation
// - correctable pulse flags all enabled live functions
// - uncorrectable pulse flags all enabled live functions
// - host function reset raises pf progress bit
// - pf progress holds until complete input
// - host vf reset raises vf progress bit
// - vf progress holds until vf complete
// - l23 request enters l23, link l3, sticky
// - request ignored in root complex mode
// - training gate low holds ltssm quiet
// - unmasked local fault drives fault output
// - eight back to back faults all reported
// - twelve fault conditions in fixed order
module pcsb_top #(
	parameter int PF_NUM    = `PCSB_PF_NUM,
	parameter int VF_NUM    = `PCSB_VF_NUM,
	parameter int LERR_DEPTH = `PCSB_LERR_DEPTH
) (
	// clock, reset, enable
	input  wire logic                     mclk_i,
	input  wire logic                     rst_i,
	input  wire logic                     ce_i,
	// configuration
	input  wire logic                     root_complex_i,
	input  wire logic [PF_NUM-1:0]        pf_enable_i,
	input  wire logic [VF_NUM-1:0]        vf_enable_i,
	input  wire pcsb_pkg::pcsb_errmsg_s   err_msg_en_i,
	// internal error reporting
	input  wire logic                     cor_err_i,
	input  wire logic                     uncor_err_i,
	input  wire logic [`PCSB_FN_NUM-1:0]  cor_sts_clr_i,
	input  wire logic [`PCSB_FN_NUM-1:0]  uncor_sts_clr_i,
	output logic [`PCSB_FN_NUM-1:0]       cor_sts_o,
	output logic [`PCSB_FN_NUM-1:0]       uncor_sts_o,
	output pcsb_pkg::pcsb_errmsg_s        err_msg_o,
	// physical function reset
	input  wire logic [PF_NUM-1:0]        pf_reset_req_i,
	input  wire logic [PF_NUM-1:0]        pf_reset_complete_i,
	output logic [PF_NUM-1:0]             pf_reset_in_progress_o,
	output logic [PF_NUM-1:0]             pf_cfg_access_en_o,
	// virtual function reset
	input  wire logic [VF_NUM-1:0]        vf_reset_req_i,
	input  wire logic [VF_NUM-1:0]        vf_reset_complete,
	output logic [VF_NUM-1:0]             vf_reset_in_progress,
	output logic [VF_NUM-1:0]             vf_cfg_access_en_o,
	// power and link
	input  wire logic                     l23_ready_entry_request,
	input  wire logic                     link_training_enable_i,
	output pcsb_pkg::pcsb_pm_e            pm_state_o,
	output pcsb_pkg::pcsb_link_s          link_ctrl_o,
	// local faults
	input  wire logic [`PCSB_LERR_NUM-1:0] local_fault_i,
	input  wire logic [`PCSB_LERR_NUM-1:0] local_int_mask_i,
	input  wire logic [`PCSB_LERR_NUM-1:0] local_sts_clr_i,
	output logic [`PCSB_LERR_NUM-1:0]      local_err_sts_o,
	output logic                           local_error_o,
	output logic [`PCSB_LERR_NUM-1:0]      local_error_code_o,
	output logic                           local_error_drop_o
);
	localparam int FN = `PCSB_FN_NUM;
	localparam int LN = `PCSB_LERR_NUM;

	// sticky status: a set in the clearing cycle wins
	function automatic logic [FN-1:0] sticky_next(input logic [FN-1:0] q,
	                                              input logic [FN-1:0] set,
	                                              input logic [FN-1:0] clr);
		return (q & ~clr) | set;
	endfunction : sticky_next

	// ==========================================================
	// internal error decode
	wire logic [PF_NUM-1:0] pf_live = pf_enable_i & PF_NUM'(`PCSB_PF_LIVE_MASK);
	wire logic [VF_NUM-1:0] vf_live = vf_enable_i & VF_NUM'(`PCSB_VF_LIVE_MASK);
	wire logic [FN-1:0]     fn_en   = FN'({vf_live, pf_live});
	wire logic [FN-1:0]     cor_set   = cor_err_i ? fn_en : '0;
	wire logic [FN-1:0]     uncor_set = uncor_err_i ? fn_en : '0;
	wire logic [FN-1:0]     cor_d     = sticky_next(cor_sts_o, cor_set, cor_sts_clr_i);
	wire logic [FN-1:0]     uncor_d   = sticky_next(uncor_sts_o, uncor_set, uncor_sts_clr_i);
	// error is not tied to a function, so one message covers all
	wire pcsb_pkg::pcsb_errmsg_s msg_d = '{
		cor:   cor_err_i && err_msg_en_i.cor && (|fn_en),
		uncor: uncor_err_i && err_msg_en_i.uncor && (|fn_en)
	};

	// aer internal error status and message strobes
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cor_sts_o   <= `PCSB_STS_RST;
			uncor_sts_o <= `PCSB_STS_RST;
			err_msg_o   <= '0;
		end else if (ce_i) begin
			cor_sts_o   <= cor_d;
			uncor_sts_o <= uncor_d;
			err_msg_o   <= msg_d;
		end
	end

	// ==========================================================
	// function level reset handshakes; reserved bits never rise
	wire logic [PF_NUM-1:0] pf_rip_d = ((pf_reset_in_progress_o & ~pf_reset_complete_i)
	                                   | pf_reset_req_i) & PF_NUM'(`PCSB_PF_LIVE_MASK);
	wire logic [VF_NUM-1:0] vf_rip_d = ((vf_reset_in_progress & ~vf_reset_complete)
	                                   | vf_reset_req_i) & VF_NUM'(`PCSB_VF_LIVE_MASK);

	// a new request in the completion cycle keeps the bit set
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pf_reset_in_progress_o <= '0;
			vf_reset_in_progress   <= '0;
			pf_cfg_access_en_o     <= '1;
			vf_cfg_access_en_o     <= '1;
		end else if (ce_i) begin
			pf_reset_in_progress_o <= pf_rip_d;
			vf_reset_in_progress   <= vf_rip_d;
			pf_cfg_access_en_o     <= ~pf_rip_d;
			vf_cfg_access_en_o     <= ~vf_rip_d;
		end
	end

	// ==========================================================
	// power state and link gate
	wire logic l23_go = l23_ready_entry_request && !root_complex_i;
	wire pcsb_pkg::pcsb_pm_e pm_d = l23_go ? pcsb_pkg::PCSB_PM_L23_READY : pm_state_o;

	// only a hard reset leaves l23 ready
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pm_state_o  <= pcsb_pkg::PCSB_PM_L0;
			link_ctrl_o <= '{hold_quiet: 1'b1, link_to_l3: 1'b0};
		end else if (ce_i) begin
			pm_state_o             <= pm_d;
			link_ctrl_o.link_to_l3 <= (pm_d == pcsb_pkg::PCSB_PM_L23_READY);
			link_ctrl_o.hold_quiet <= !link_training_enable_i;
		end
	end

	// ==========================================================
	// local fault status and event queue
	wire logic [LN-1:0] lerr_unmasked = local_fault_i & ~local_int_mask_i;
	wire logic [LN-1:0] lerr_sts_d    = sticky_next(local_err_sts_o, local_fault_i,
	                                                local_sts_clr_i);
	wire logic          q_valid;
	wire logic [LN-1:0] q_data;
	wire logic          q_drop;

	// queue spreads a burst over consecutive report cycles
	pcsb_fault_q #(
		.WIDTH (LN),
		.DEPTH (LERR_DEPTH)
	) u_fault_q (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.push_i  (|lerr_unmasked),
		.data_i  (lerr_unmasked),
		.valid_o (q_valid),
		.data_o  (q_data),
		.drop_o  (q_drop)
	);

	// report register; the code names which conditions fired
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			local_err_sts_o    <= `PCSB_STS_RST;
			local_error_o      <= 1'b0;
			local_error_code_o <= '0;
			local_error_drop_o <= 1'b0;
		end else if (ce_i) begin
			local_err_sts_o    <= lerr_sts_d;
			local_error_o      <= q_valid;
			local_error_code_o <= q_valid ? q_data : '0;
			local_error_drop_o <= q_drop;
		end
	end

	// ==========================================================
	// checks
	sequence s_fault_on_idle;
		ce_i && (|lerr_unmasked) && !q_valid ##1 ce_i;
	endsequence
	sequence s_quiet_idle;
		ce_i && !(|lerr_unmasked) && !q_valid ##1 ce_i;
	endsequence

	AST_COR_SET: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && cor_err_i) |=> ((cor_sts_o & $past(fn_en)) == $past(fn_en)))
		else $error("correctable status not set in enabled function");

	AST_UNCOR_SET: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && uncor_err_i && err_msg_en_i.uncor && (|fn_en))
		|=> (err_msg_o.uncor && ((uncor_sts_o & $past(fn_en)) == $past(fn_en))))
		else $error("uncorrectable report missing");

	AST_PF_RISE: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> ((pf_reset_in_progress_o & PF_NUM'(`PCSB_PF_LIVE_MASK))
		          == (($past(pf_reset_req_i) | $past(pf_reset_in_progress_o))
		              & PF_NUM'(`PCSB_PF_LIVE_MASK) & ~($past(pf_reset_complete_i)
		              & ~$past(pf_reset_req_i)))))
		else $error("pf reset progress bit wrong");

	AST_PF_ACCESS: assert property (@(posedge mclk_i) disable iff (rst_i)
		(pf_cfg_access_en_o == ~pf_reset_in_progress_o)
		&& (pf_reset_in_progress_o[PF_NUM-1:2] == '0))
		else $error("pf access gate or reserved bits wrong");

	AST_VF_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> ((($past(vf_reset_in_progress) & ~$past(vf_reset_complete))
		          & ~vf_reset_in_progress) == '0) && (vf_reset_in_progress[VF_NUM-1:6] == '0))
		else $error("vf reset progress dropped early");

	AST_VF_RISE: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && vf_reset_req_i[0]) |=> (vf_reset_in_progress[0] && !vf_cfg_access_en_o[0]))
		else $error("vf reset progress not raised");

	AST_L23_ENTER: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && l23_ready_entry_request && !root_complex_i)
		|=> (pm_state_o == pcsb_pkg::PCSB_PM_L23_READY && link_ctrl_o.link_to_l3))
		else $error("l23 ready not entered");

	AST_L23_RC: assert property (@(posedge mclk_i) disable iff (rst_i)
		(root_complex_i && pm_state_o == pcsb_pkg::PCSB_PM_L0)
		|=> (pm_state_o == $past(pm_state_o)))
		else $error("l23 request honoured in root complex mode");

	AST_L23_STICK: assert property (@(posedge mclk_i) disable iff (rst_i)
		(pm_state_o == pcsb_pkg::PCSB_PM_L23_READY)
		|=> (pm_state_o == pcsb_pkg::PCSB_PM_L23_READY))
		else $error("l23 ready left without reset");

	AST_LTSSM_GATE: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> (link_ctrl_o.hold_quiet == !$past(link_training_enable_i)))
		else $error("ltssm gate not followed");

	AST_LERR_REPORT: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_fault_on_idle |=> (local_error_o && local_error_code_o == $past(lerr_unmasked, 2)))
		else $error("unmasked local fault not reported");

	AST_LERR_MASK: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_quiet_idle |=> !local_error_o)
		else $error("masked local fault reported");
endmodule : pcsb_top

// ==== pcsb_user_model.sv ====
`timescale 1ns/1ps

// ==========================================================
// user-side function reset responder
module pcsb_user_model (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	// stall control from the bench
	input  wire logic       hold_i,
	// reset handshake
	input  wire logic [3:0] pf_prog_i,
	input  wire logic [7:0] vf_prog_i,
	output logic      [3:0] pf_done_o,
	output logic      [7:0] vf_done_o
);
	logic [1:0] cnt_q;

	// completes only pending functions, after a few cycles of local work;
	// rising edge with non-blocking updates, so no race with the bench
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q     <= 2'h0;
			pf_done_o <= 4'h0;
			vf_done_o <= 8'h0;
		end else if (hold_i || (pf_prog_i == 4'h0 && vf_prog_i == 8'h0)) begin
			cnt_q     <= 2'h0;
			pf_done_o <= 4'h0;
			vf_done_o <= 8'h0;
		end else begin
			cnt_q     <= cnt_q + 2'h1;
			pf_done_o <= (cnt_q == 2'h3) ? pf_prog_i : 4'h0;
			vf_done_o <= (cnt_q == 2'h3) ? vf_prog_i : 8'h0;
		end
	end
endmodule : pcsb_user_model

// ==== tb_pcsb_top.sv ====
`timescale 1ns/1ps
`include "pcsb_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_pcsb_top;
	// ==========================================================
	// stimulus and observed signals
	typedef struct packed {
		logic [3:0]  pf;
		logic [7:0]  vf;
		logic [1:0]  me;
		logic        c;
		logic        u;
		logic [11:0] ec;
		logic [11:0] eu;
		logic [1:0]  em;
	} pcsb_row_s;
	logic                   mclk_i = 1'h0;
	logic                   rst_i  = 1'h1;
	logic                   ce_i   = 1'h1;
	logic                   rc = 1'h0, cor = 1'h0, uncor = 1'h0;
	logic                   l23 = 1'h0, lte = 1'h0, hold = 1'h1;
	logic [3:0]             pf_en = 4'h0, pf_req = 4'h0, pf_done, pf_prog, pf_acc;
	logic [7:0]             vf_en = 8'h0, vf_req = 8'h0, vf_done, vf_prog, vf_acc;
	logic [11:0]            cclr = 12'h0, uclr = 12'h0, lf = 12'h0, lmask = 12'h0;
	logic [11:0]            lclr = 12'h0, csts, usts, lsts, lcode;
	logic                   lerr, ldrop;
	pcsb_pkg::pcsb_errmsg_s msg_en = 2'h0, msg;
	pcsb_pkg::pcsb_pm_e     pm;
	pcsb_pkg::pcsb_link_s   lnk;
	int                     n_mismatch = 0, check_count = 0, k;
	pcsb_row_s              rows [4] = '{
		'{4'hf, 8'hff, 2'h3, 1'h1, 1'h0, 12'h3f3, 12'h000, 2'h2},
		'{4'h1, 8'h00, 2'h1, 1'h0, 1'h1, 12'h000, 12'h001, 2'h1},
		'{4'h0, 8'h00, 2'h3, 1'h1, 1'h1, 12'h000, 12'h000, 2'h0},
		'{4'h2, 8'h05, 2'h0, 1'h1, 1'h1, 12'h052, 12'h052, 2'h0}};

	// 250 MHz clock
	always #2 mclk_i = ~mclk_i;

	pcsb_top pcsb_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
		.root_complex_i(rc), .pf_enable_i(pf_en), .vf_enable_i(vf_en),
		.err_msg_en_i(msg_en), .cor_err_i(cor), .uncor_err_i(uncor),
		.cor_sts_clr_i(cclr), .uncor_sts_clr_i(uclr), .cor_sts_o(csts),
		.uncor_sts_o(usts), .err_msg_o(msg), .pf_reset_req_i(pf_req),
		.pf_reset_complete_i(pf_done), .pf_reset_in_progress_o(pf_prog),
		.pf_cfg_access_en_o(pf_acc), .vf_reset_req_i(vf_req),
		.vf_reset_complete(vf_done), .vf_reset_in_progress(vf_prog),
		.vf_cfg_access_en_o(vf_acc), .l23_ready_entry_request(l23),
		.link_training_enable_i(lte), .pm_state_o(pm), .link_ctrl_o(lnk),
		.local_fault_i(lf), .local_int_mask_i(lmask), .local_sts_clr_i(lclr),
		.local_err_sts_o(lsts), .local_error_o(lerr), .local_error_code_o(lcode),
		.local_error_drop_o(ldrop));

	pcsb_user_model pcsb_user_model_inst (.mclk_i(mclk_i), .rst_i(rst_i),
		.hold_i(hold), .pf_prog_i(pf_prog), .vf_prog_i(vf_prog),
		.pf_done_o(pf_done), .vf_done_o(vf_done));

	// ==========================================================
	// verdict
	task automatic summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	// hang guard, well beyond the fewer than one hundred cycles of the sequence
	initial begin
		repeat (3000) @(posedge mclk_i);
		n_mismatch++;
		summarize();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (6) @(negedge mclk_i);
		rst_i = 1'h0;
		@(negedge mclk_i);
		// table of internal error cases
		foreach (rows[i]) begin
			pf_en = rows[i].pf; vf_en = rows[i].vf; msg_en = rows[i].me;
			cor = rows[i].c; uncor = rows[i].u;
			@(negedge mclk_i);
			cor = 1'h0; uncor = 1'h0;
			`CHK(csts, rows[i].ec)
			`CHK(usts, rows[i].eu)
			`CHK(msg, rows[i].em)
			@(negedge mclk_i);
			`CHK(msg, 2'h0)
			cclr = 12'hfff; uclr = 12'hfff;
			@(negedge mclk_i);
			cclr = 12'h0; uclr = 12'h0;
		end
		// set against clear in one cycle; set has priority
		pf_en = 4'hf; vf_en = 8'hff; cor = 1'h1; cclr = 12'hfff;
		@(negedge mclk_i);
		cor = 1'h0; cclr = 12'h0;
		`CHK(csts, 12'h3f3)
		cclr = 12'hfff; ce_i = 1'h0; uncor = 1'h1;
		@(negedge mclk_i);
		ce_i = 1'h1; uncor = 1'h0; cclr = 12'h0;
		`CHK(usts, 12'h000)
		`CHK(csts, 12'h3f3)
		// function resets, far side stalled, reserved bits included
		pf_req = 4'hf; vf_req = 8'hff;
		@(negedge mclk_i);
		pf_req = 4'h0; vf_req = 8'h0;
		`CHK(pf_prog, 4'h3)
		`CHK(pf_acc, 4'hc)
		`CHK(vf_prog, 8'h3f)
		repeat (6) @(negedge mclk_i);
		`CHK(pf_prog, 4'h3)
		`CHK(vf_acc, 8'hc0)
		hold = 1'h0;
		for (k = 0; k < 20 && pf_prog !== 4'h0; k++) @(negedge mclk_i);
		@(negedge mclk_i);
		`CHK(pf_prog, 4'h0)
		`CHK({vf_prog, vf_acc}, 16'h00ff)
		// link gate and power requests; functions taken as already in d3
		`CHK(lnk.hold_quiet, 1'h1)
		lte = 1'h1; rc = 1'h1; l23 = 1'h1;
		@(negedge mclk_i);
		`CHK(lnk.hold_quiet, 1'h0)
		@(negedge mclk_i);
		`CHK(pm, pcsb_pkg::PCSB_PM_L0)
		rc = 1'h0;
		@(negedge mclk_i);
		l23 = 1'h0;
		`CHK(pm, pcsb_pkg::PCSB_PM_L23_READY)
		repeat (3) @(negedge mclk_i);
		`CHK(lnk.link_to_l3, 1'h1)
		rst_i = 1'h1;
		@(negedge mclk_i);
		`CHK({pm, lnk}, 3'h2)
		`CHK({csts, pf_acc}, 16'h000f)
		rst_i = 1'h0;
		@(negedge mclk_i);
		// every fault condition alone
		for (k = 0; k < 12; k++) begin
			lf = 12'h1 << k;
			@(negedge mclk_i);
			lf = 12'h0;
			@(negedge mclk_i);
			`CHK({lerr, lcode}, {1'h1, 12'h1 << k})
			`CHK(lsts, 12'h1 << k)
			lclr = 12'hfff;
			@(negedge mclk_i);
			lclr = 12'h0;
			`CHK(lerr, 1'h0)
		end
		// masked condition is recorded but not signalled
		lmask = 12'h020; lf = 12'h020;
		repeat (3) begin
			@(negedge mclk_i);
			lf = 12'h0;
			`CHK(lerr, 1'h0)
		end
		`CHK(lsts, 12'h020)
		lmask = 12'h0;
		// eight back to back events, none lost
		for (k = 0; k < 9; k++) begin
			lf = (k < 8) ? (12'h1 << k) : 12'h0;
			@(negedge mclk_i);
			if (k >= 1)
				`CHK({lerr, lcode, ldrop}, {1'h1, 12'h1 << (k - 1), 1'h0})
		end
		// last entry drained at the previous edge, so the report is idle
		lf = 12'h0;
		@(negedge mclk_i);
		`CHK({lerr, lcode}, {1'h0, 12'h000})
		summarize();
	end
endmodule : tb_pcsb_top
